//--- design/susp_res_ctrl.sv
// design: global suspend / resume control of a usb host controller command register
`timescale 1ns/100ps
module susp_res_ctrl #(
  parameter int BUS_RST_CYC = susp_res_pkg::BUS_RST_CYC,
  parameter int EOP_CYC     = susp_res_pkg::EOP_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        connect_evt_i,
  input  wire logic        disconnect_evt_i,
  input  wire logic        k_state_i,
  input  wire logic        xact_busy_i,
  output logic             drive_resume_o,
  output logic             drive_eop_o,
  output logic             drive_bus_reset_o,
  output logic             run_enable_o,
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // input synchronisers (bus-side levels come from pins)
  // ---------------------------------------------------------------
  logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  always_comb begin
    nxt_sync1 = {k_state_i, disconnect_evt_i, connect_evt_i};
    nxt_sync2 = sync1_ff;
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ---------------------------------------------------------------
  // bus access: one wait cycle, answer on the second edge
  // ---------------------------------------------------------------
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic acc, wr_take, rd_take;
  assign acc = (avs_read_i | avs_write_i) & ~ack_ff;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
  assign wr_take = avs_write_i & ack_ff & avs_byteenable_i[0];
  assign rd_take = avs_read_i & ~ack_ff;
  assign avs_readdata_o = rdata_ff;

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  logic [4:0] cmd_ff, nxt_cmd;
  logic [susp_res_pkg::IRQ_W-1:0] stat_ff, nxt_stat, en_ff, nxt_en;
  logic halted_ff, nxt_halted;
  logic [31:0] cnt_ff, nxt_cnt;
  susp_res_pkg::sig_state_type st_ff, nxt_st;
  logic suspended, wake_evt, fr_wr, fr_fall, rst_wr;
  logic [susp_res_pkg::IRQ_W-1:0] evt;
  logic [4:0] wcmd;

  assign wcmd = avs_writedata_i[4:0];
  assign suspended = cmd_ff[susp_res_pkg::SUSPEND_BIT];
  assign wake_evt = suspended & ~cmd_ff[susp_res_pkg::RESUME_BIT] & (|sync2_ff);
  assign fr_wr = wr_take & (avs_address_i == susp_res_pkg::CMD_IDX);
  // the stored bit stays high during resume and EOP, so the fall is taken from the write itself
  assign fr_fall = fr_wr & (st_ff == susp_res_pkg::ST_RESUME)
                   & ~wcmd[susp_res_pkg::RESUME_BIT];
  assign rst_wr = fr_wr & wcmd[susp_res_pkg::RESET_BIT];

  always_comb begin
    nxt_ack = acc;
    nxt_rdata = rdata_ff;
    nxt_cmd = cmd_ff;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_halted = halted_ff;
    nxt_en = en_ff;
    evt = '0;
    if (fr_wr) begin
      nxt_cmd = wcmd;
      // bit stays one while resume or EOP still runs on the bus
      if (st_ff == susp_res_pkg::ST_RESUME || st_ff == susp_res_pkg::ST_EOP) begin
        nxt_cmd[susp_res_pkg::RESUME_BIT] = 1'b1;
      end
    end
    if (wake_evt) begin
      nxt_cmd[susp_res_pkg::RESUME_BIT] = 1'b1;
      evt[susp_res_pkg::IRQ_RESUME_BIT] = 1'b1;
    end
    unique case (st_ff)
      susp_res_pkg::ST_IDLE: begin
        if (rst_wr) begin
          nxt_st = susp_res_pkg::ST_BUSRST;
          nxt_cnt = 32'h0;
        end else if (nxt_cmd[susp_res_pkg::RESUME_BIT]) begin
          nxt_st = susp_res_pkg::ST_RESUME;
        end
      end
      susp_res_pkg::ST_RESUME: begin
        if (fr_fall) begin
          nxt_st = susp_res_pkg::ST_EOP;
          nxt_cnt = 32'h0;
        end
      end
      susp_res_pkg::ST_EOP: begin
        nxt_cnt = cnt_ff + 32'h1;
        if (cnt_ff >= 32'(EOP_CYC - 1)) begin
          nxt_st = susp_res_pkg::ST_IDLE;
          nxt_cmd[susp_res_pkg::RESUME_BIT] = 1'b0;
          evt[susp_res_pkg::IRQ_EOP_BIT] = 1'b1;
        end
      end
      susp_res_pkg::ST_BUSRST: begin
        // reset on the bus lasts until software clears the bit; logic held in reset state
        if (cnt_ff < 32'(BUS_RST_CYC)) begin
          nxt_cnt = cnt_ff + 32'h1;
        end
        nxt_cmd = susp_res_pkg::CMD_RST;
        nxt_cmd[susp_res_pkg::RESET_BIT] = 1'b1;
        nxt_halted = 1'b1;
        if (fr_wr && !wcmd[susp_res_pkg::RESET_BIT]) begin
          nxt_cmd = wcmd;
          nxt_st = susp_res_pkg::ST_IDLE;
        end
      end
      default: nxt_st = susp_res_pkg::ST_IDLE;
    endcase
    // halted once run is off and the current transaction has ended
    if (!cmd_ff[susp_res_pkg::RUN_BIT] && !xact_busy_i && !halted_ff) begin
      nxt_halted = 1'b1;
      evt[susp_res_pkg::IRQ_HALT_BIT] = 1'b1;
    end else if (cmd_ff[susp_res_pkg::RUN_BIT] && !suspended) begin
      nxt_halted = 1'b0;
    end
    if (wr_take && avs_address_i == susp_res_pkg::IRQ_EN_IDX) begin
      nxt_en = avs_writedata_i[susp_res_pkg::IRQ_W-1:0];
    end
    nxt_stat = stat_ff;
    if (wr_take && avs_address_i == susp_res_pkg::IRQ_CLR_IDX) begin
      nxt_stat = stat_ff & ~avs_writedata_i[susp_res_pkg::IRQ_W-1:0];
    end
    nxt_stat = nxt_stat | evt; // set wins over a clear in the same cycle
    if (rd_take) begin
      nxt_rdata = 32'h0;
      unique case (avs_address_i)
        susp_res_pkg::CMD_IDX:      nxt_rdata[4:0] = cmd_ff;
        susp_res_pkg::STATE_IDX: begin
          nxt_rdata[susp_res_pkg::HALTED_BIT] = halted_ff;
          nxt_rdata[susp_res_pkg::SUSPENDED_BIT] = suspended;
          nxt_rdata[susp_res_pkg::EOP_BIT] = (st_ff == susp_res_pkg::ST_EOP);
          nxt_rdata[susp_res_pkg::BUSRST_BIT] = (st_ff == susp_res_pkg::ST_BUSRST);
        end
        susp_res_pkg::IRQ_STAT_IDX: nxt_rdata[susp_res_pkg::IRQ_W-1:0] = stat_ff;
        susp_res_pkg::IRQ_EN_IDX:   nxt_rdata[susp_res_pkg::IRQ_W-1:0] = en_ff;
        default:                    nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ack_ff    <= 1'b0;
      rdata_ff  <= 32'h0;
      cmd_ff    <= susp_res_pkg::CMD_RST;
      st_ff     <= susp_res_pkg::ST_IDLE;
      cnt_ff    <= 32'h0;
      halted_ff <= 1'b1;
      stat_ff   <= susp_res_pkg::IRQ_RST;
      en_ff     <= susp_res_pkg::IRQ_RST;
    end else begin
      ack_ff    <= nxt_ack;
      rdata_ff  <= nxt_rdata;
      cmd_ff    <= nxt_cmd;
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      halted_ff <= nxt_halted;
      stat_ff   <= nxt_stat;
      en_ff     <= nxt_en;
    end
  end

  // ---------------------------------------------------------------
  // bus drive outputs
  // ---------------------------------------------------------------
  logic res_ff, eop_ff, brst_ff, run_ff, irq_ff;
  logic nxt_res, nxt_eop, nxt_brst, nxt_run, nxt_irq;
  always_comb begin
    nxt_res  = (nxt_st == susp_res_pkg::ST_RESUME);
    nxt_eop  = (nxt_st == susp_res_pkg::ST_EOP);
    nxt_brst = (nxt_st == susp_res_pkg::ST_BUSRST);
    // suspended or resuming: no transactions may be scheduled
    nxt_run  = nxt_cmd[susp_res_pkg::RUN_BIT] & ~nxt_cmd[susp_res_pkg::SUSPEND_BIT]
               & (nxt_st == susp_res_pkg::ST_IDLE);
    nxt_irq  = |(nxt_stat & nxt_en);
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      res_ff  <= 1'b0;
      eop_ff  <= 1'b0;
      brst_ff <= 1'b0;
      run_ff  <= 1'b0;
      irq_ff  <= 1'b0;
    end else begin
      res_ff  <= nxt_res;
      eop_ff  <= nxt_eop;
      brst_ff <= nxt_brst;
      run_ff  <= nxt_run;
      irq_ff  <= nxt_irq;
    end
  end
  assign drive_resume_o    = res_ff;
  assign drive_eop_o       = eop_ff;
  assign drive_bus_reset_o = brst_ff;
  assign run_enable_o      = run_ff;
  assign irq_o             = irq_ff;
endmodule

//--- shared/susp_res_pkg.sv
// package: register map, field positions, reset values and timing for suspend/resume control
package susp_res_pkg;
  // ---------------------------------------------------------------
  // register word offsets (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_IDX       = 4'h0;
  localparam logic [3:0] STATE_IDX     = 4'h1;
  localparam logic [3:0] IRQ_STAT_IDX  = 4'h2;
  localparam logic [3:0] IRQ_EN_IDX    = 4'h3;
  localparam logic [3:0] IRQ_CLR_IDX   = 4'h4;
  // ---------------------------------------------------------------
  // command register fields
  // ---------------------------------------------------------------
  localparam int RUN_BIT     = 0;
  localparam int RESET_BIT   = 2;
  localparam int SUSPEND_BIT = 3;
  localparam int RESUME_BIT  = 4;
  // ---------------------------------------------------------------
  // state register fields
  // ---------------------------------------------------------------
  localparam int HALTED_BIT   = 0;
  localparam int SUSPENDED_BIT = 1;
  localparam int EOP_BIT      = 2;
  localparam int BUSRST_BIT   = 3;
  // ---------------------------------------------------------------
  // interrupt status fields
  // ---------------------------------------------------------------
  localparam int IRQ_RESUME_BIT = 0;
  localparam int IRQ_EOP_BIT    = 1;
  localparam int IRQ_HALT_BIT   = 2;
  localparam int IRQ_W          = 3;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [4:0] CMD_RST       = 5'h00;
  localparam logic [2:0] IRQ_RST       = 3'h0;
  localparam int         CLK_MHZ       = 50;
  localparam int         EOP_NS        = 1333;
  localparam int         EOP_CYC       = (EOP_NS * CLK_MHZ) / 1000;
  localparam int         BUS_RST_MS    = 10;
  localparam int         BUS_RST_CYC   = BUS_RST_MS * CLK_MHZ * 1000;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_RESUME = 4'b0010,
    ST_EOP    = 4'b0100,
    ST_BUSRST = 4'b1000
  } sig_state_type;
endpackage

//--- verification/susp_res_properties.sv
// checker: output timing of the suspend/resume control seen at its ports
`timescale 1ns/100ps
module susp_res_ctrl_checker #(
  parameter int EOP_CYC = susp_res_pkg::EOP_CYC
) (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        drive_resume_o,
  input wire logic        drive_eop_o,
  input wire logic        drive_bus_reset_o,
  input wire logic        run_enable_o,
  input wire logic        irq_o
);
  logic        cmd_wr, clr_now, clr1_ff, clr2_ff;
  logic [15:0] eop_cnt_ff, nxt_eop_cnt;
  assign cmd_wr  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                   && avs_address_i == susp_res_pkg::CMD_IDX;
  assign clr_now = cmd_wr && !avs_writedata_i[4];
  always_comb nxt_eop_cnt = drive_eop_o ? eop_cnt_ff + 16'h0001 : 16'h0000;
  // a clearing write reaches the resume output one clock after it is taken
  always_ff @(posedge sys_clk_i) begin
    eop_cnt_ff <= sys_rst_i ? 16'h0000 : nxt_eop_cnt;
    clr1_ff    <= clr_now;
    clr2_ff    <= clr1_ff;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_eop_length: assert property ($fell(drive_eop_o) |-> eop_cnt_ff == EOP_CYC)
    else $error("eop length wrong");
  a_eop_after_resume: assert property ($rose(drive_eop_o) |-> $past(drive_resume_o))
    else $error("eop without resume");
  a_resume_ends_eop: assert property ($fell(drive_resume_o) |-> drive_eop_o || drive_bus_reset_o)
    else $error("resume ended without eop");
  a_resume_holds: assert property (drive_resume_o && !clr_now && !clr1_ff && !clr2_ff |=> drive_resume_o)
    else $error("resume dropped early");
  a_resume_no_run: assert property (drive_resume_o || drive_eop_o |-> !run_enable_o)
    else $error("run while resuming");
  a_suspend_stops_run: assert property (cmd_wr && avs_writedata_i[3] |-> ##[1:3] !run_enable_o)
    else $error("run during suspend");
  a_bus_reset_drive: assert property (cmd_wr && avs_writedata_i[2] |-> ##[1:3] drive_bus_reset_o)
    else $error("bus reset not driven");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=> !(drive_resume_o || drive_eop_o
    || drive_bus_reset_o || run_enable_o || irq_o)) else $error("outputs active after reset");
endmodule
bind susp_res_ctrl susp_res_ctrl_checker #(.EOP_CYC(EOP_CYC)) chk (.*);

//--- verification/usb_dev_model.sv
// partner: attached devices raising connect, disconnect or k-state wake conditions
`timescale 1ns/100ps
module usb_dev_model #(
  parameter int HOLD = 4
) (
  input  wire logic       sys_clk_i,
  input  wire logic [2:0] wake_i,
  output logic      [2:0] line_o
);
  logic [2:0] line_ff = 3'h0;
  logic [2:0] nxt_line;
  logic [3:0] cnt_ff = 4'h0;
  logic [3:0] nxt_cnt;
  // a condition lasts a few clocks, then the lines fall back to idle
  always_comb begin
    nxt_line = line_ff;
    nxt_cnt  = cnt_ff;
    if (cnt_ff != 4'h0) nxt_cnt = cnt_ff - 4'h1;
    else if (wake_i != 3'h0) begin
      nxt_line = wake_i;
      nxt_cnt  = HOLD[3:0];
    end
    if (cnt_ff == 4'h1) nxt_line = 3'h0;
  end
  always_ff @(posedge sys_clk_i) begin
    line_ff <= nxt_line;
    cnt_ff  <= nxt_cnt;
  end
  assign line_o = line_ff;
endmodule

//--- verification/usb_global_suspend_resume_tb.sv
// testbench: register-level checks of suspend, wake, eop and bus reset
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module usb_global_suspend_resume_tb;
  logic        sys_clk_i, sys_rst_i, avs_read_i, avs_write_i, xact_busy_i;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic        avs_waitrequest_o, connect_evt_i, disconnect_evt_i, k_state_i;
  logic        drive_resume_o, drive_eop_o, drive_bus_reset_o, run_enable_o, irq_o;
  logic [2:0]  wake;
  int          err_count, checks, n;
  susp_res_ctrl #(.BUS_RST_CYC(50)) dut (.*);
  usb_dev_model dev (.sys_clk_i(sys_clk_i), .wake_i(wake),
                     .line_o({k_state_i, disconnect_evt_i, connect_evt_i}));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    n = 0;
    // values read right after the edge are those the design showed at that edge
    do begin @(posedge sys_clk_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) `CHK("waitrequest", 1'b0, avs_waitrequest_o)
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    complete_run();
  end
  initial begin
    {avs_read_i, avs_write_i, xact_busy_i, avs_address_i, avs_writedata_i, wake} = '0;
    avs_byteenable_i = 4'hF;
    sys_rst_i = 1'b1;
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk_rd(susp_res_pkg::STATE_IDX, 32'h1, "state reset");
    xact_busy_i <= 1'b1;
    bus(1'b1, susp_res_pkg::CMD_IDX, 32'h1);
    `CHK("run", 1'b1, run_enable_o)
    bus(1'b1, susp_res_pkg::CMD_IDX, 32'h0);
    chk_rd(susp_res_pkg::STATE_IDX, 32'h0, "state busy");
    xact_busy_i <= 1'b0;
    chk_rd(susp_res_pkg::STATE_IDX, 32'h1, "state idle");
    chk_rd(susp_res_pkg::IRQ_STAT_IDX, 32'h4, "halt status");
    bus(1'b1, susp_res_pkg::IRQ_CLR_IDX, 32'h7);
    bus(1'b1, susp_res_pkg::IRQ_EN_IDX, 32'h1);
    // a write without lane 0 is ignored, an unmapped index reads zero
    avs_byteenable_i <= 4'h0;
    bus(1'b1, susp_res_pkg::IRQ_EN_IDX, 32'h7);
    avs_byteenable_i <= 4'hF;
    chk_rd(susp_res_pkg::IRQ_EN_IDX, 32'h1, "lane0 refused");
    chk_rd(4'h7, 32'h0, "unmapped read");
    // connect, disconnect and k-state each wake the suspended bus
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, susp_res_pkg::CMD_IDX, 32'h8);
      chk_rd(susp_res_pkg::STATE_IDX, 32'h3, "suspended");
      wake <= 3'h1 << k;
      @(posedge sys_clk_i);
      wake <= 3'h0;
      n = 0;
      while (irq_o !== 1'b1 && n < 40) begin @(negedge sys_clk_i); n++; end
      `CHK("irq", 1'b1, irq_o)
      `CHK("resume", 1'b1, drive_resume_o)
      chk_rd(susp_res_pkg::CMD_IDX, 32'h18, "cmd wake");
      chk_rd(susp_res_pkg::IRQ_STAT_IDX, 32'h1, "wake status");
      bus(1'b1, susp_res_pkg::CMD_IDX, 32'h8);
      `CHK("eop", 1'b1, drive_eop_o)
      chk_rd(susp_res_pkg::CMD_IDX, 32'h18, "cmd eop");
      n = 0;
      while (drive_eop_o !== 1'b0 && n < 200) begin @(negedge sys_clk_i); n++; end
      chk_rd(susp_res_pkg::CMD_IDX, 32'h8, "cmd done");
      `CHK("resume end", 1'b0, drive_resume_o)
      bus(1'b1, susp_res_pkg::CMD_IDX, 32'h0);
      chk_rd(susp_res_pkg::IRQ_STAT_IDX, 32'h3, "eop status");
      bus(1'b1, susp_res_pkg::IRQ_CLR_IDX, 32'h1);
      `CHK("irq masked", 1'b0, irq_o)
      bus(1'b1, susp_res_pkg::IRQ_CLR_IDX, 32'h2);
    end
    bus(1'b1, susp_res_pkg::CMD_IDX, 32'h4);
    `CHK("bus reset on", 1'b1, drive_bus_reset_o)
    bus(1'b1, susp_res_pkg::CMD_IDX, 32'h0);
    `CHK("bus reset off", 1'b0, drive_bus_reset_o)
    complete_run();
  end
endmodule
